// *** src/lcd_reset_pkg.sv ***
// Shared constants and types for the display driver system reset block.
package lcd_reset_pkg;

  // Internal clock rate and the period of the modelled RC timebase.
  localparam int REF_CLK_MHZ = 250;
  localparam int RC_OSC_PERIOD_NS = 2000;
  localparam int RC_HALF_CYCLES = (RC_OSC_PERIOD_NS * REF_CLK_MHZ) / 1000 / 2;
  localparam int RC_CNT_W = 10;
  localparam logic [RC_CNT_W-1:0] RC_HALF_LAST = RC_CNT_W'(RC_HALF_CYCLES - 1);

  // Frame layout on the serial link; the last bit sent lands in bit 0.
  localparam int FRAME_BITS = 56;
  localparam int IDX_LSB = 0;
  localparam int IDX_W = 2;
  localparam int CTL_VALID_BIT = 2;
  localparam int KEY_READ_BIT = 3;
  localparam int MARK_LSB = 4;
  localparam int MARK_W = 4;
  localparam logic [MARK_W-1:0] MARK_VALUE = 4'ha;
  localparam int CTL_SRC_BIT = 8;
  localparam int CTL_ROLE_BIT = 9;
  localparam int CTL_FOUR_LINE_BIT = 10;
  localparam int CTL_SCAN_OFF_BIT = 11;
  localparam int CTL_ALL_OFF_BIT = 12;
  localparam int PIX_LSB = 14;
  localparam int PIX_W = 42;
  localparam int PIX_CHUNKS = 4;

  // Display bit totals per multiplex mode and the transfers each needs.
  localparam int DISPLAY_BITS_THREE = 126;
  localparam int DISPLAY_BITS_FOUR = 164;
  localparam logic [PIX_CHUNKS-1:0] NEED_THREE_LINE = 4'h7;
  localparam logic [PIX_CHUNKS-1:0] NEED_FOUR_LINE = 4'hf;

  // Pin and key widths.
  localparam int KEY_W = 30;
  localparam int SEG_W = 42;
  localparam int COM_W = 4;
  localparam int PORT_W = 4;
  localparam int SEG_ONLY_W = 34;
  localparam int SHARED_SCAN_W = 3;
  localparam int UPPER_SCAN_W = 3;

  // Control reset values at power-up.
  localparam logic CTL_SRC_RESET = 1'b0;
  localparam logic CTL_ROLE_RESET = 1'b0;
  localparam logic CTL_FOUR_LINE_RESET = 1'b0;
  localparam logic CTL_SCAN_OFF_RESET = 1'b0;
  localparam logic CTL_ALL_OFF_RESET = 1'b0;

  // Key scan controller states.
  typedef enum logic [2:0] {
    KEY_IDLE = 3'b001,
    KEY_SCAN = 3'b010,
    KEY_REQ = 3'b100
  } key_state_e;

endpackage : lcd_reset_pkg

// *** src/sync_2ff.sv ***
// Two flip-flop synchroniser for signals from outside the internal clock domain.
`timescale 1ns/1ps
`default_nettype none

module sync_2ff #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] stage_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_stage;

  // The first stage feeds only the second stage.
  always_comb begin
    nxt_meta = async_in;
    nxt_stage = meta_ff;
    if (!nrst) begin
      nxt_meta = '0;
      nxt_stage = '0;
    end
  end

  // Register both stages.
  always_ff @(posedge ref_clk) begin
    meta_ff <= nxt_meta;
    stage_ff <= nxt_stage;
  end

  assign sync_out = stage_ff;

endmodule : sync_2ff
`default_nettype wire

// *** src/lcd_key_driver_system_reset.sv ***
// System reset, timebase gating, key scan hold-off and pin forcing for the display driver.
//
// Operation
// - Reset at power-up and on supply drop.
// - Reset blanks display, halts scan, clears keys.
// - Release re-enables display and key scanning.
// - Release on strobe fall ending last transfer.
// - Reset stops the timebase in both sources.
// - Display off, latch still takes pixel data.
// - Key scanner initialised and disabled in reset.
// - Serial and shift logic never reset; control only at power-up.
// - Port and shared scan pins: segment, low.
// - Scan, segment, first common outputs held low.
// - Fourth pin common until role bit arrives.
// - Timebase pin high impedance during reset.
// - Key request released in reset, even reads.
// - Source bit: zero internal, one external.
// - Pending key read pulls request line low.
`timescale 1ns/1ps
`default_nettype none

module lcd_key_driver_system_reset (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic supply_drop_detector,
  input wire logic link_clk,
  input wire logic link_strobe,
  input wire logic link_data,
  input wire logic [lcd_reset_pkg::KEY_W-1:0] key_sense,
  input wire logic timebase_pin_in,
  output logic timebase_pin_out,
  output logic timebase_pin_oe,
  output logic timebase_tick,
  input wire logic [lcd_reset_pkg::SEG_W-1:0] seg_wave,
  input wire logic [lcd_reset_pkg::COM_W-1:0] com_wave,
  output logic [lcd_reset_pkg::PORT_W-1:0] segment_or_port_pins,
  output logic [lcd_reset_pkg::SEG_ONLY_W-1:0] segment_pins,
  output logic [lcd_reset_pkg::COM_W-2:0] common_lines,
  output logic shared_fourth_line_pin,
  output logic fourth_pin_is_common,
  output logic [lcd_reset_pkg::SHARED_SCAN_W-1:0] shared_scan_segment_pins,
  output logic shared_scan_is_scan,
  output logic [lcd_reset_pkg::UPPER_SCAN_W-1:0] upper_scan_lines,
  output logic key_req_out,
  output logic key_req_oe,
  output logic [lcd_reset_pkg::KEY_W-1:0] key_bits,
  output logic [lcd_reset_pkg::PIX_CHUNKS*lcd_reset_pkg::PIX_W-1:0] pixel_bits,
  output logic system_reset,
  output logic display_on
);
  import lcd_reset_pkg::*;

  // Link domain: shift register that follows the serial clock.
  logic [FRAME_BITS-1:0] link_word_ff;
  logic [FRAME_BITS-1:0] nxt_link_word;

  // Synchronised inputs.
  logic det_s;
  logic strobe_s;
  logic ext_s;
  logic [KEY_W-1:0] keys_s;

  // Frame decode in the internal domain.
  logic strobe_d_ff;
  logic frame_end;
  logic frame_take;
  logic [IDX_W-1:0] frame_idx;
  logic frame_ctl;
  logic frame_key_read;

  // Reset, release tracking and control state.
  logic rst_ff;
  logic [PIX_CHUNKS-1:0] done_ff;
  logic ctl_seen_ff;
  logic src_ff;
  logic role_ff;
  logic role_known_ff;
  logic four_ff;
  logic scan_off_ff;
  logic all_off_ff;
  logic [PIX_W-1:0] pix_ff [PIX_CHUNKS];
  logic nxt_rst;
  logic [PIX_CHUNKS-1:0] nxt_done;
  logic nxt_ctl_seen;
  logic nxt_src;
  logic nxt_role;
  logic nxt_role_known;
  logic nxt_four;
  logic nxt_scan_off;
  logic nxt_all_off;
  logic [PIX_W-1:0] nxt_pix [PIX_CHUNKS];
  logic [PIX_CHUNKS-1:0] need_mask;
  logic mode_four;

  // Timebase state.
  logic [RC_CNT_W-1:0] rc_cnt_ff;
  logic rc_level_ff;
  logic ext_d_ff;
  logic tick_ff;
  logic [RC_CNT_W-1:0] nxt_rc_cnt;
  logic nxt_rc_level;
  logic nxt_ext_d;
  logic nxt_tick;
  logic run_rc;

  // Key scan state.
  key_state_e key_state_ff;
  key_state_e nxt_key_state;
  logic [KEY_W-1:0] key_bits_ff;
  logic [KEY_W-1:0] sample_ff;
  logic [KEY_W-1:0] nxt_key_bits;
  logic [KEY_W-1:0] nxt_sample;

  // Registered pin states.
  logic [SEG_W-1:0] seg_ff;
  logic [COM_W-1:0] com_ff;
  logic fourth_common_ff;
  logic scan_lines_ff;
  logic disp_ff;
  logic [SEG_W-1:0] nxt_seg;
  logic [COM_W-1:0] nxt_com;
  logic nxt_fourth_common;
  logic nxt_scan_lines;
  logic nxt_disp;

  // Shift on every rising link clock edge inside a frame; no reset, transfers survive system reset.
  always_comb begin
    nxt_link_word = link_word_ff;
    if (link_strobe) begin
      nxt_link_word = {link_word_ff[FRAME_BITS-2:0], link_data};
    end
  end

  // Register the link shift register on the link clock.
  always_ff @(posedge link_clk) begin
    link_word_ff <= nxt_link_word;
  end

  // Bring the detector, strobe, external clock and key lines into the internal domain.
  sync_2ff #(.WIDTH(1)) u_sync_det (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .async_in(supply_drop_detector),
    .sync_out(det_s)
  );

  sync_2ff #(.WIDTH(1)) u_sync_strobe (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .async_in(link_strobe),
    .sync_out(strobe_s)
  );

  sync_2ff #(.WIDTH(1)) u_sync_ext (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .async_in(timebase_pin_in),
    .sync_out(ext_s)
  );

  sync_2ff #(.WIDTH(KEY_W)) u_sync_keys (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .async_in(key_sense),
    .sync_out(keys_s)
  );

  // The word is stable once the strobe has fallen, since the link clock then stands still.
  assign frame_end = strobe_d_ff & ~strobe_s;
  assign frame_take = frame_end & (link_word_ff[MARK_LSB +: MARK_W] == MARK_VALUE);
  assign frame_idx = link_word_ff[IDX_LSB +: IDX_W];
  assign frame_ctl = link_word_ff[CTL_VALID_BIT];
  assign frame_key_read = link_word_ff[KEY_READ_BIT];
  assign mode_four = frame_ctl ? link_word_ff[CTL_FOUR_LINE_BIT] : four_ff;
  assign need_mask = mode_four ? NEED_FOUR_LINE : NEED_THREE_LINE;

  // Reset entry, release tracking, control and pixel latch.
  always_comb begin
    nxt_rst = rst_ff;
    nxt_done = done_ff;
    nxt_ctl_seen = ctl_seen_ff;
    nxt_src = src_ff;
    nxt_role = role_ff;
    nxt_role_known = role_known_ff;
    nxt_four = four_ff;
    nxt_scan_off = scan_off_ff;
    nxt_all_off = all_off_ff;
    for (int i = 0; i < PIX_CHUNKS; i++) begin
      nxt_pix[i] = pix_ff[i];
    end
    if (frame_take && !frame_key_read) begin
      nxt_pix[frame_idx] = link_word_ff[PIX_LSB +: PIX_W];
      if (frame_ctl) begin
        nxt_src = link_word_ff[CTL_SRC_BIT];
        nxt_role = link_word_ff[CTL_ROLE_BIT];
        nxt_role_known = 1'b1;
        nxt_four = link_word_ff[CTL_FOUR_LINE_BIT];
        nxt_scan_off = link_word_ff[CTL_SCAN_OFF_BIT];
        nxt_all_off = link_word_ff[CTL_ALL_OFF_BIT];
      end
      if (rst_ff) begin
        nxt_done = done_ff | (4'h1 << frame_idx);
        nxt_ctl_seen = ctl_seen_ff | frame_ctl;
        if (((nxt_done & need_mask) == need_mask) && nxt_ctl_seen) begin
          nxt_rst = 1'b0;
        end
      end
    end
    if (det_s) begin
      nxt_rst = 1'b1;
      nxt_done = '0;
      nxt_ctl_seen = 1'b0;
    end
    if (!nrst) begin
      nxt_rst = 1'b1;
      nxt_done = '0;
      nxt_ctl_seen = 1'b0;
      nxt_src = CTL_SRC_RESET;
      nxt_role = CTL_ROLE_RESET;
      nxt_role_known = 1'b0;
      nxt_four = CTL_FOUR_LINE_RESET;
      nxt_scan_off = CTL_SCAN_OFF_RESET;
      nxt_all_off = CTL_ALL_OFF_RESET;
      for (int i = 0; i < PIX_CHUNKS; i++) begin
        nxt_pix[i] = '0;
      end
    end
  end

  // Register reset, control and latch state.
  always_ff @(posedge ref_clk) begin
    rst_ff <= nxt_rst;
    done_ff <= nxt_done;
    ctl_seen_ff <= nxt_ctl_seen;
    src_ff <= nxt_src;
    role_ff <= nxt_role;
    role_known_ff <= nxt_role_known;
    four_ff <= nxt_four;
    scan_off_ff <= nxt_scan_off;
    all_off_ff <= nxt_all_off;
    strobe_d_ff <= strobe_s;
    for (int i = 0; i < PIX_CHUNKS; i++) begin
      pix_ff[i] <= nxt_pix[i];
    end
  end

  // Timebase: RC divider or external clock edges, both stopped while reset holds.
  assign run_rc = ~rst_ff & ~src_ff;
  always_comb begin
    nxt_rc_cnt = '0;
    nxt_rc_level = 1'b0;
    nxt_tick = 1'b0;
    nxt_ext_d = ext_s;
    if (run_rc) begin
      nxt_rc_level = rc_level_ff;
      nxt_rc_cnt = rc_cnt_ff + 1'b1;
      if (rc_cnt_ff == RC_HALF_LAST) begin
        nxt_rc_cnt = '0;
        nxt_rc_level = ~rc_level_ff;
        nxt_tick = ~rc_level_ff;
      end
    end else if (!rst_ff) begin
      nxt_tick = ext_s & ~ext_d_ff;
    end
    if (!nrst) begin
      nxt_ext_d = 1'b0;
      nxt_tick = 1'b0;
    end
  end

  // Register the timebase.
  always_ff @(posedge ref_clk) begin
    rc_cnt_ff <= nxt_rc_cnt;
    rc_level_ff <= nxt_rc_level;
    ext_d_ff <= nxt_ext_d;
    tick_ff <= nxt_tick;
  end

  // Key scanner: confirm two equal samples on timebase ticks, then raise a read request.
  always_comb begin
    nxt_key_state = key_state_ff;
    nxt_key_bits = key_bits_ff;
    nxt_sample = sample_ff;
    case (key_state_ff)
      KEY_IDLE: begin
        if (|keys_s) begin
          nxt_key_state = KEY_SCAN;
          nxt_sample = keys_s;
        end
      end
      KEY_SCAN: begin
        if (tick_ff) begin
          if (!(|keys_s)) begin
            nxt_key_state = KEY_IDLE;
          end else if (keys_s == sample_ff) begin
            nxt_key_bits = keys_s;
            nxt_key_state = KEY_REQ;
          end else begin
            nxt_sample = keys_s;
          end
        end
      end
      KEY_REQ: begin
        if (frame_take && frame_key_read) begin
          nxt_key_state = KEY_SCAN;
          nxt_sample = keys_s;
        end
      end
      default: begin
        nxt_key_state = KEY_IDLE;
      end
    endcase
    if (rst_ff || scan_off_ff || !nrst) begin
      nxt_key_state = KEY_IDLE;
      nxt_key_bits = '0;
      nxt_sample = '0;
    end
  end

  // Register the key scanner.
  always_ff @(posedge ref_clk) begin
    key_state_ff <= nxt_key_state;
    key_bits_ff <= nxt_key_bits;
    sample_ff <= nxt_sample;
  end

  // Pin states: drive levels low during reset, fourth-pin role follows the role bit; normal drive after release.
  always_comb begin
    nxt_disp = ~rst_ff & ~all_off_ff;
    nxt_seg = nxt_disp ? seg_wave : '0;
    nxt_com = nxt_disp ? com_wave : '0;
    nxt_fourth_common = ~role_known_ff | ~role_ff;
    if (!nxt_fourth_common) begin
      nxt_com[COM_W-1] = nxt_disp & seg_wave[COM_W-1+SEG_ONLY_W+PORT_W];
    end
    nxt_scan_lines = ~rst_ff & ~scan_off_ff;
    if (!nrst) begin
      nxt_disp = 1'b0;
      nxt_seg = '0;
      nxt_com = '0;
      nxt_fourth_common = 1'b1;
      nxt_scan_lines = 1'b0;
    end
  end

  // Register pin states.
  always_ff @(posedge ref_clk) begin
    disp_ff <= nxt_disp;
    seg_ff <= nxt_seg;
    com_ff <= nxt_com;
    fourth_common_ff <= nxt_fourth_common;
    scan_lines_ff <= nxt_scan_lines;
  end

  // Output mapping; the timebase pin floats during reset and in external mode.
  assign timebase_pin_out = rc_level_ff;
  assign timebase_pin_oe = run_rc;
  assign timebase_tick = tick_ff;
  assign segment_or_port_pins = seg_ff[PORT_W-1:0];
  assign segment_pins = seg_ff[PORT_W +: SEG_ONLY_W];
  assign common_lines = com_ff[COM_W-2:0];
  assign shared_fourth_line_pin = com_ff[COM_W-1];
  assign fourth_pin_is_common = fourth_common_ff;
  assign shared_scan_segment_pins = {SHARED_SCAN_W{scan_lines_ff}};
  assign shared_scan_is_scan = scan_lines_ff;
  assign upper_scan_lines = {UPPER_SCAN_W{scan_lines_ff}};

  // Request line pulls low only while pending, out of reset and between frames.
  assign key_req_out = 1'b0;
  assign key_req_oe = (key_state_ff == KEY_REQ) & ~rst_ff & ~strobe_s;
  assign key_bits = key_bits_ff;
  assign system_reset = rst_ff;
  assign display_on = disp_ff;

  // Flatten the pixel latch, chunk 0 in the low bits.
  always_comb begin
    for (int i = 0; i < PIX_CHUNKS; i++) begin
      pixel_bits[i*PIX_W +: PIX_W] = pix_ff[i];
    end
  end

endmodule : lcd_key_driver_system_reset
`default_nettype wire

// *** bench/link_host.sv ***
// Behavioural system controller that sends frames on the serial link.
`timescale 1ns/1ps
`default_nettype none

module link_host (
  output logic link_clk,
  output logic link_strobe,
  output logic link_data
);
  // The link rests with its clock stopped low and the strobe low.
  initial begin
    link_clk = 1'b0;
    link_strobe = 1'b0;
    link_data = 1'b1;
  end

  // Sends one frame, first bit at the top; the clock runs only inside the frame.
  task automatic send(input logic [55:0] w);
    #5 link_strobe = 1'b1;
    for (int i = 55; i >= 0; i--) begin
      link_data = w[i];
      #6 link_clk = 1'b1;
      #6 link_clk = 1'b0;
    end
    #5 link_strobe = 1'b0;
    link_data = ~w[0]; // A released data line must not show the last bit.
    #40;
  endtask : send
endmodule : link_host
`default_nettype wire

// *** bench/lcd_reset_props.sv ***
// Checker for the pin states and release timing of the system reset block.
`timescale 1ns/1ps
`default_nettype none

module lcd_reset_props (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic supply_drop_detector,
  input wire logic link_strobe,
  input wire logic timebase_pin_oe,
  input wire logic timebase_tick,
  input wire logic [lcd_reset_pkg::PORT_W-1:0] segment_or_port_pins,
  input wire logic [lcd_reset_pkg::SEG_ONLY_W-1:0] segment_pins,
  input wire logic [lcd_reset_pkg::COM_W-2:0] common_lines,
  input wire logic shared_fourth_line_pin,
  input wire logic fourth_pin_is_common,
  input wire logic [lcd_reset_pkg::SHARED_SCAN_W-1:0] shared_scan_segment_pins,
  input wire logic shared_scan_is_scan,
  input wire logic [lcd_reset_pkg::UPPER_SCAN_W-1:0] upper_scan_lines,
  input wire logic key_req_oe,
  input wire logic [lcd_reset_pkg::KEY_W-1:0] key_bits,
  input wire logic system_reset,
  input wire logic display_on
);
  import lcd_reset_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // Three cycles of reset give every forced pin time to settle.
  sequence held;
    system_reset [*3];
  endsequence

  a_drop_forces_reset: assert property (supply_drop_detector [*6] |-> system_reset)
    else $error("supply drop did not apply reset");
  a_release_after_strobe: assert property ($fell(system_reset) |-> !$past(link_strobe, 1) && !$past(link_strobe, 2))
    else $error("reset released while strobe high");
  a_power_up_common: assert property ($rose(nrst) |-> fourth_pin_is_common && !shared_fourth_line_pin)
    else $error("fourth pin not common and low at power-up");
  a_display_blanked: assert property (held |-> !display_on && shared_fourth_line_pin == 1'b0)
    else $error("display on during reset");
  a_drivers_held_low: assert property (held |-> segment_pins == '0 && common_lines == '0 && upper_scan_lines == '0)
    else $error("driver outputs not low during reset");
  a_port_pins_low: assert property (held |-> segment_or_port_pins == '0 && shared_scan_segment_pins == '0 && !shared_scan_is_scan)
    else $error("shared pins not segment low during reset");
  a_keys_cleared: assert property (held |-> key_bits == '0)
    else $error("key data not cleared during reset");
  a_request_released: assert property (held |-> !key_req_oe)
    else $error("key request pulled during reset");
  a_timebase_hiz: assert property (held |-> !timebase_pin_oe)
    else $error("timebase pin driven during reset");
  a_timebase_halted: assert property (held |-> !timebase_tick)
    else $error("timebase ticking during reset");

  c_release: cover property ($fell(system_reset));
  c_drop: cover property ($rose(system_reset));
  c_key_request: cover property (key_req_oe);
endmodule : lcd_reset_props

bind lcd_key_driver_system_reset lcd_reset_props i_props (
  .ref_clk(ref_clk), .nrst(nrst), .supply_drop_detector(supply_drop_detector), .link_strobe(link_strobe),
  .timebase_pin_oe(timebase_pin_oe), .timebase_tick(timebase_tick), .segment_pins(segment_pins),
  .segment_or_port_pins(segment_or_port_pins), .common_lines(common_lines), .key_bits(key_bits),
  .shared_fourth_line_pin(shared_fourth_line_pin), .fourth_pin_is_common(fourth_pin_is_common),
  .shared_scan_segment_pins(shared_scan_segment_pins), .shared_scan_is_scan(shared_scan_is_scan),
  .upper_scan_lines(upper_scan_lines), .key_req_oe(key_req_oe), .system_reset(system_reset),
  .display_on(display_on)
);
`default_nettype wire

// *** bench/lcd_key_driver_system_reset_test.sv ***
// Self-checking bench for the display driver system reset block.
`timescale 1ns/1ps
`default_nettype none

module lcd_key_driver_system_reset_test;
  import lcd_reset_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic supply_drop_detector = 1'b0;
  logic [KEY_W-1:0] key_sense = '0;
  logic [3:0] ext_cnt = 4'h0;
  wire logic link_clk;
  wire logic link_strobe;
  wire logic link_data;
  logic timebase_pin_out, timebase_pin_oe, timebase_tick, key_req_out, key_req_oe;
  logic system_reset, display_on, fourth_pin_is_common;
  logic [KEY_W-1:0] key_bits;
  logic [PIX_CHUNKS*PIX_W-1:0] pixel_bits;
  logic [PORT_W-1:0] segment_or_port_pins;
  logic [SEG_ONLY_W-1:0] segment_pins;
  logic [COM_W-2:0] common_lines;
  logic [SHARED_SCAN_W-1:0] shared_scan_segment_pins;
  logic [UPPER_SCAN_W-1:0] upper_scan_lines;
  logic shared_fourth_line_pin, shared_scan_is_scan;
  // Waveform patterns fed to the drivers, so that released pins can be told from forced ones.
  localparam logic [SEG_W-1:0] SEG_PAT = {21{2'b10}};
  localparam logic [COM_W-1:0] COM_PAT = 4'ha;
  int n_errors = 0;
  int tests_run = 0;

  // Clock at 250 MHz, and an external timebase that runs all the time.
  always #2 ref_clk = ~ref_clk;
  always @(negedge ref_clk) ext_cnt <= ext_cnt + 4'h1;

  // Pin levels: the timebase pin sees whoever drives it, the request line has a pull-up.
  wire logic tb_wire = timebase_pin_oe ? timebase_pin_out : ext_cnt[2];
  wire logic key_req_line = key_req_oe ? key_req_out : 1'b1;

  lcd_key_driver_system_reset i_dut (
    .ref_clk(ref_clk), .nrst(nrst), .supply_drop_detector(supply_drop_detector),
    .link_clk(link_clk), .link_strobe(link_strobe), .link_data(link_data), .key_sense(key_sense),
    .timebase_pin_in(tb_wire), .timebase_pin_out(timebase_pin_out), .timebase_pin_oe(timebase_pin_oe),
    .timebase_tick(timebase_tick), .seg_wave(SEG_PAT), .com_wave(COM_PAT),
    .segment_or_port_pins(segment_or_port_pins), .segment_pins(segment_pins), .common_lines(common_lines),
    .shared_fourth_line_pin(shared_fourth_line_pin), .fourth_pin_is_common(fourth_pin_is_common),
    .shared_scan_segment_pins(shared_scan_segment_pins), .shared_scan_is_scan(shared_scan_is_scan),
    .upper_scan_lines(upper_scan_lines), .key_req_out(key_req_out), .key_req_oe(key_req_oe), .key_bits(key_bits),
    .pixel_bits(pixel_bits), .system_reset(system_reset), .display_on(display_on)
  );
  link_host i_host (.link_clk(link_clk), .link_strobe(link_strobe), .link_data(link_data));

  // Compares one value and counts the outcome.
  task automatic chk(input string what, input logic [167:0] seen, input logic [167:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  function automatic logic [41:0] pix(input logic [1:0] idx);
    return 42'h1234567890a ^ {40'h0, idx};
  endfunction : pix

  // Builds a frame: pixels, control flags, marker, key read, control valid, chunk index.
  function automatic logic [55:0] frame(input logic [1:0] idx, input logic ctl, input logic four,
      input logic src, input logic role, input logic key);
    return {pix(idx), 3'b000, four, role, src, MARK_VALUE, key, ctl, idx};
  endfunction : frame

  task automatic send(input logic [55:0] w);
    i_host.send(w);
    cyc(8);
  endtask : send

  task automatic t_power_up;
    chk("system_reset", system_reset, 1);
    chk("fourth_pin_is_common", fourth_pin_is_common, 1);
    chk("timebase_pin_oe", timebase_pin_oe, 0);
    chk("key_req_line", key_req_line, 1);
    chk("segment_or_port_pins", segment_or_port_pins, 0);
    chk("segment_pins", segment_pins, 0);
    chk("common_lines", common_lines, 0);
    chk("shared_fourth_line_pin", shared_fourth_line_pin, 0);
    chk("upper_scan_lines", upper_scan_lines, 0);
  endtask : t_power_up

  // Three-line release: two chunks keep reset, the third with control releases it.
  task automatic t_three_line;
    send(frame(2'd0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    chk("pixel chunk 0", pixel_bits[PIX_W-1:0], pix(2'd0));
    send(frame(2'd1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    chk("system_reset", system_reset, 1);
    send(frame(2'd2, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0));
    chk("system_reset", system_reset, 0);
    chk("display_on", display_on, 1);
    chk("timebase_pin_oe", timebase_pin_oe, 1);
    chk("fourth_pin_is_common", fourth_pin_is_common, 0);
    chk("segment_or_port_pins", segment_or_port_pins, SEG_PAT[PORT_W-1:0]);
    chk("segment_pins", segment_pins, SEG_PAT[PORT_W +: SEG_ONLY_W]);
    chk("common_lines", common_lines, COM_PAT[COM_W-2:0]);
    chk("shared_fourth_line_pin", shared_fourth_line_pin, SEG_PAT[SEG_W-1]);
    chk("upper_scan_lines", upper_scan_lines, 3'h7);
    chk("shared_scan_is_scan", shared_scan_is_scan, 1);
  endtask : t_three_line

  // A held key raises the request, and a key read clears it.
  task automatic t_key;
    key_sense = 30'h00000421;
    for (int i = 0; i < 4000 && key_req_oe !== 1'b1; i++) cyc(1);
    chk("key_req_line", key_req_line, 0);
    chk("key_bits", key_bits, 30'h00000421);
    send(frame(2'd0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1));
    chk("key_req_line", key_req_line, 1);
  endtask : t_key

  // Supply drop, a read in reset, then four-line release on external timebase.
  task automatic t_drop_four;
    int ticks;
    ticks = 0;
    supply_drop_detector = 1'b1;
    cyc(6);
    chk("system_reset", system_reset, 1);
    chk("key_bits", key_bits, 0);
    chk("display_on", display_on, 0);
    chk("segment_pins", segment_pins, 0);
    chk("shared_scan_segment_pins", shared_scan_segment_pins, 0);
    chk("shared_scan_is_scan", shared_scan_is_scan, 0);
    chk("shared_fourth_line_pin", shared_fourth_line_pin, 0);
    chk("timebase_pin_oe", timebase_pin_oe, 0);
    supply_drop_detector = 1'b0;
    send(frame(2'd0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1));
    chk("key_req_line", key_req_line, 1);
    for (int i = 0; i < 3; i++) send(frame(2'(i), i == 2, 1'b1, 1'b1, 1'b1, 1'b0));
    chk("system_reset", system_reset, 1);
    send(frame(2'd3, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    chk("system_reset", system_reset, 0);
    chk("pixel chunk 3", pixel_bits[3*PIX_W +: PIX_W], pix(2'd3));
    chk("timebase_pin_oe", timebase_pin_oe, 0);
    for (int i = 0; i < 40; i++) begin
      cyc(1);
      ticks += int'(timebase_tick === 1'b1);
    end
    chk("ext ticks seen", ticks > 0, 1);
    chk("key_bits", key_bits, 30'h00000421);
  endtask : t_drop_four

  // Control frame with all-off and scan-off set, then a control frame that clears both.
  task automatic t_off;
    send(frame(2'd0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0) | (56'h1 << CTL_ALL_OFF_BIT) | (56'h1 << CTL_SCAN_OFF_BIT));
    chk("display_on", display_on, 0);
    chk("shared_scan_is_scan", shared_scan_is_scan, 0);
    chk("key_bits", key_bits, 0);
    send(frame(2'd0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0));
    chk("display_on", display_on, 1);
    chk("shared_scan_is_scan", shared_scan_is_scan, 1);
  endtask : t_off

  task automatic test_done;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  // Main sequence after ten cycles of reset.
  initial begin
    cyc(10);
    t_power_up();
    nrst = 1'b1;
    cyc(4);
    t_three_line();
    t_key();
    t_drop_four();
    t_off();
    test_done();
  end

  // Cuts a hang short well beyond the expected run.
  initial begin
    #100000;
    n_errors++;
    test_done();
  end
endmodule : lcd_key_driver_system_reset_test
`default_nettype wire
